// File: logic/sqa_pkg.sv
// Constants, types and shared arithmetic for the square/accumulate and status-op unit.
//
// Overview of operation
// - Square-and-accumulate first adds the shifted product register to the accumulator.
// - Then it loads the addressed word into the operand register and squares it.
// - Square-and-subtract first subtracts the shifted product register from the accumulator.
// - Then it loads the addressed word into the operand register and squares it.
// - Store-status writes status word zero to the addressed data word.
// - Indexed store-status writes the status word chosen by the immediate index.
// - Second-status store writes status word one to the addressed data word.
// - Set-sign-extension forces the sign extension mode bit to one.
// - Set-test-flag forces the test/control flag to one, other bits unchanged.
// - On the legacy variant, set-transmit-mode forces the transmit mode bit to one.
// - Product shift: 00 none, 01 left 1, 10 left 4, 11 right 6 signed.
package sqa_pkg;

  typedef enum logic [2:0] {
    SQA_IDLE = 3'b001,
    SQA_EXEC = 3'b010,
    SQA_CAPT = 3'b100
  } sqa_state_t;

  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_STATUS0 = 8'h08;
  localparam logic [7:0] A_STATUS1 = 8'h0C;
  localparam logic [7:0] A_ACC = 8'h10;
  localparam logic [7:0] A_PREG = 8'h14;
  localparam logic [7:0] A_TREG = 8'h18;
  localparam logic [7:0] A_AUX = 8'h1C;
  localparam logic [7:0] A_CFG = 8'h20;

  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_SQ_ACC = 4'h1;
  localparam logic [3:0] OP_SQ_SUB = 4'h2;
  localparam logic [3:0] OP_STORE_S0 = 4'h3;
  localparam logic [3:0] OP_STORE_IDX = 4'h4;
  localparam logic [3:0] OP_STORE_S1 = 4'h5;
  localparam logic [3:0] OP_SET_SEXT = 4'h6;
  localparam logic [3:0] OP_SET_TEST = 4'h7;
  localparam logic [3:0] OP_SET_XMIT = 4'h8;

  localparam int CMD_OP_LSB = 0;
  localparam int CMD_IND = 4;
  localparam int CMD_DMA_LSB = 5;
  localparam int CMD_NXT_EN = 12;
  localparam int CMD_NXT_LSB = 13;
  localparam int CMD_IDX = 16;
  localparam int AUX_SEL_LSB = 16;

  localparam int S0_PTR_LSB = 13;
  localparam int S0_PAGE_LSB = 0;
  localparam int S1_TEST = 11;
  localparam int S1_SEXT = 10;
  localparam int S1_XMIT = 2;
  localparam int S1_PSHIFT_LSB = 0;

  localparam logic [15:0] S0_RST = 16'h0600;
  localparam logic [15:0] S1_RST = 16'h05F0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Product output shifter shared by both accumulate directions.
  function automatic logic [31:0] sqa_pshift(input logic [31:0] p, input logic [1:0] sel);
    logic [31:0] r;
    r = p;
    case (sel)
      2'h1: r = {p[30:0], 1'h0};
      2'h2: r = {p[27:0], 4'h0};
      2'h3: r = {{6{p[31]}}, p[31:6]};
      default: r = p;
    endcase
    return r;
  endfunction

  // Merges a bus write into a stored word under its byte enables.
  function automatic logic [31:0] sqa_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// File: logic/sqa_sq_if.sv
// Interface between the core and the squarer/shifter datapath.
`timescale 1ns/1ns
`default_nettype none
interface sqa_sq_if;
  logic [15:0] operand;
  logic [31:0] square;
  logic [31:0] pin;
  logic [1:0] shsel;
  logic [31:0] pout;
  modport core (output operand, output pin, output shsel, input square, input pout);
  modport unit (input operand, input pin, input shsel, output square, output pout);
endinterface
`default_nettype wire

// File: logic/sqa_square.sv
// Squarer and product output shifter.
`timescale 1ns/1ns
`default_nettype none
module sqa_square (
  sqa_sq_if.unit sq
);
  logic signed [31:0] prod;

  always_comb begin
    prod = 32'(($signed(sq.operand)) * ($signed(sq.operand)));
  end

  assign sq.square = prod;
  assign sq.pout = sqa_pkg::sqa_pshift(sq.pin, sq.shsel);
endmodule // sqa_square
`default_nettype wire

// File: logic/sqa_agu.sv
// Operand address generator for direct and indirect forms.
`timescale 1ns/1ns
`default_nettype none
module sqa_agu (
  input wire logic indirect,
  input wire logic [6:0] dma,
  input wire logic [8:0] dp,
  input wire logic [15:0] ar_cur,
  input wire logic [2:0] ptr,
  input wire logic nxt_en,
  input wire logic [2:0] nxt_ptr,
  output logic [15:0] addr,
  output logic [2:0] ptr_new
);
  always_comb begin
    addr = indirect ? ar_cur : {dp, dma};
    // The pointer changes only after the address above has been formed from the old one.
    ptr_new = (indirect && nxt_en) ? nxt_ptr : ptr;
  end
endmodule // sqa_agu
`default_nettype wire

// File: logic/sqa_top.sv
// Instruction execution core with AXI4-Lite register access and data-memory port.
`timescale 1ns/1ns
`default_nettype none
module sqa_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [15:0] mem_wdata,
  input wire logic [15:0] mem_rdata
);
  typedef struct packed {
    sqa_pkg::sqa_state_t st;
    logic [31:0] acc;
    logic [31:0] preg;
    logic [15:0] treg;
    logic [15:0] sw0;
    logic [15:0] sw1;
    logic [7:0][15:0] ar;
    logic [31:0] cmd;
    logic legacy;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } sqa_core_t;

  localparam sqa_core_t CORE_RST = '{
    st: sqa_pkg::SQA_IDLE, acc: 32'h0, preg: 32'h0, treg: 16'h0,
    sw0: sqa_pkg::S0_RST, sw1: sqa_pkg::S1_RST, ar: '0, cmd: 32'h0,
    legacy: 1'h0, mem_addr: 16'h0, mem_wdata: 16'h0, mem_rd: 1'h0, mem_wr: 1'h0,
    bvalid: 1'h0, bresp: 2'h0, rvalid: 1'h0, rresp: 2'h0, rdata: 32'h0};

  sqa_core_t q;
  sqa_core_t d;
  logic wr_take;
  logic rd_take;
  logic go;
  logic busy;
  logic [31:0] wval;
  logic [3:0] wop;
  logic [15:0] agu_addr;
  logic [2:0] agu_ptr;
  logic [3:0] cur_op;

  sqa_sq_if sq ();

  sqa_square u_square (
    .sq(sq.unit)
  );

  sqa_agu u_agu (
    .indirect(wval[sqa_pkg::CMD_IND]),
    .dma(wval[sqa_pkg::CMD_DMA_LSB +: 7]),
    .dp(q.sw0[sqa_pkg::S0_PAGE_LSB +: 9]),
    .ar_cur(q.ar[q.sw0[sqa_pkg::S0_PTR_LSB +: 3]]),
    .ptr(q.sw0[sqa_pkg::S0_PTR_LSB +: 3]),
    .nxt_en(wval[sqa_pkg::CMD_NXT_EN]),
    .nxt_ptr(wval[sqa_pkg::CMD_NXT_LSB +: 3]),
    .addr(agu_addr),
    .ptr_new(agu_ptr)
  );

  assign sq.operand = mem_rdata;
  assign sq.pin = q.preg;
  assign sq.shsel = q.sw1[sqa_pkg::S1_PSHIFT_LSB +: 2];

  assign busy = ~q.st[0];
  assign cur_op = q.cmd[sqa_pkg::CMD_OP_LSB +: 4];
  // Write address and data are taken together, only while no response is pending.
  assign wr_take = ce & s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
  assign rd_take = ce & s_axi_arvalid & ~q.rvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = rd_take;
  // Valids are masked while frozen so that no handshake completes unseen.
  assign s_axi_bvalid = q.bvalid & ce;
  assign s_axi_rvalid = q.rvalid & ce;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign mem_addr = q.mem_addr;
  assign mem_rd = q.mem_rd;
  assign mem_wr = q.mem_wr;
  assign mem_wdata = q.mem_wdata;

  always_comb begin
    wval = sqa_pkg::sqa_merge(32'h0, s_axi_wdata, s_axi_wstrb);
    unique case (s_axi_awaddr)
      sqa_pkg::A_CMD: wval = sqa_pkg::sqa_merge(q.cmd, s_axi_wdata, s_axi_wstrb);
      sqa_pkg::A_STATUS0: wval = sqa_pkg::sqa_merge({16'h0, q.sw0}, s_axi_wdata, s_axi_wstrb);
      sqa_pkg::A_STATUS1: wval = sqa_pkg::sqa_merge({16'h0, q.sw1}, s_axi_wdata, s_axi_wstrb);
      sqa_pkg::A_AUX: wval = sqa_pkg::sqa_merge({16'h0, q.ar[s_axi_wdata[sqa_pkg::AUX_SEL_LSB +: 3]]},
                                                s_axi_wdata, s_axi_wstrb);
      sqa_pkg::A_ACC: wval = sqa_pkg::sqa_merge(q.acc, s_axi_wdata, s_axi_wstrb);
      sqa_pkg::A_PREG: wval = sqa_pkg::sqa_merge(q.preg, s_axi_wdata, s_axi_wstrb);
      default: wval = sqa_pkg::sqa_merge(32'h0, s_axi_wdata, s_axi_wstrb);
    endcase
  end

  assign wop = wval[sqa_pkg::CMD_OP_LSB +: 4];

  always_comb begin
    d = q;
    go = 1'b0;
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    unique case (q.st)
      sqa_pkg::SQA_IDLE: begin
      end
      sqa_pkg::SQA_EXEC: begin
        d.mem_rd = 1'b0;
        d.mem_wr = 1'b0;
        d.st = q.mem_rd ? sqa_pkg::SQA_CAPT : sqa_pkg::SQA_IDLE;
      end
      sqa_pkg::SQA_CAPT: begin
        d.treg = mem_rdata;
        d.preg = sq.square;
        d.st = sqa_pkg::SQA_IDLE;
      end
      default: d.st = sqa_pkg::SQA_IDLE;
    endcase

    if (wr_take) begin
      d.bvalid = 1'b1;
      d.bresp = sqa_pkg::RESP_OKAY;
      // Nothing is written while an instruction runs, so the engine owns the state.
      if (busy) begin
        d.bresp = sqa_pkg::RESP_SLVERR;
      end else begin
        unique case (s_axi_awaddr)
          sqa_pkg::A_CMD: begin
            d.cmd = wval;
            go = 1'b1;
          end
          sqa_pkg::A_STATUS0: d.sw0 = wval[15:0];
          sqa_pkg::A_STATUS1: d.sw1 = wval[15:0];
          sqa_pkg::A_ACC: d.acc = wval;
          sqa_pkg::A_PREG: d.preg = wval;
          sqa_pkg::A_AUX: begin
            if (s_axi_wstrb[2]) begin
              d.ar[s_axi_wdata[sqa_pkg::AUX_SEL_LSB +: 3]] = wval[15:0];
            end
          end
          sqa_pkg::A_CFG: begin
            if (s_axi_wstrb[0]) begin
              d.legacy = s_axi_wdata[0];
            end
          end
          default: d.bresp = sqa_pkg::RESP_SLVERR;
        endcase
      end
    end

    if (go) begin
      unique case (wop)
        sqa_pkg::OP_SQ_ACC, sqa_pkg::OP_SQ_SUB, sqa_pkg::OP_STORE_S0, sqa_pkg::OP_STORE_IDX,
        sqa_pkg::OP_STORE_S1: begin
          d.mem_addr = agu_addr;
          d.sw0[sqa_pkg::S0_PTR_LSB +: 3] = agu_ptr;
          d.st = sqa_pkg::SQA_EXEC;
        end
        default: begin
        end
      endcase
      unique case (wop)
        sqa_pkg::OP_SQ_ACC: begin
          d.acc = q.acc + sq.pout;
          d.mem_rd = 1'b1;
        end
        sqa_pkg::OP_SQ_SUB: begin
          d.acc = q.acc - sq.pout;
          d.mem_rd = 1'b1;
        end
        sqa_pkg::OP_STORE_S0: begin
          d.mem_wr = 1'b1;
          d.mem_wdata = q.sw0;
        end
        sqa_pkg::OP_STORE_IDX: begin
          d.mem_wr = 1'b1;
          d.mem_wdata = wval[sqa_pkg::CMD_IDX] ? q.sw1 : q.sw0;
        end
        sqa_pkg::OP_STORE_S1: begin
          d.mem_wr = 1'b1;
          d.mem_wdata = q.sw1;
        end
        sqa_pkg::OP_SET_SEXT: d.sw1[sqa_pkg::S1_SEXT] = 1'b1;
        sqa_pkg::OP_SET_TEST: d.sw1[sqa_pkg::S1_TEST] = 1'b1;
        sqa_pkg::OP_SET_XMIT: begin
          if (q.legacy) begin
            d.sw1[sqa_pkg::S1_XMIT] = 1'b1;
          end
        end
        sqa_pkg::OP_NOP: begin
        end
        default: d.bresp = sqa_pkg::RESP_SLVERR;
      endcase
    end

    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rresp = sqa_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        sqa_pkg::A_CMD: d.rdata = q.cmd;
        sqa_pkg::A_STAT: d.rdata = {28'h0, q.st, busy};
        sqa_pkg::A_STATUS0: d.rdata = {16'h0, q.sw0};
        sqa_pkg::A_STATUS1: d.rdata = {16'h0, q.sw1};
        sqa_pkg::A_ACC: d.rdata = q.acc;
        sqa_pkg::A_PREG: d.rdata = q.preg;
        sqa_pkg::A_TREG: d.rdata = {16'h0, q.treg};
        sqa_pkg::A_AUX: d.rdata = {13'h0, q.sw0[sqa_pkg::S0_PTR_LSB +: 3],
                                   q.ar[q.sw0[sqa_pkg::S0_PTR_LSB +: 3]]};
        sqa_pkg::A_CFG: d.rdata = {31'h0, q.legacy};
        default: begin
          d.rdata = 32'h0;
          d.rresp = sqa_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= CORE_RST;
    end else if (ce) begin
      q <= d;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_acc_add;
    go && wop == sqa_pkg::OP_SQ_ACC |=>
      q.acc == $past(q.acc) + sqa_pkg::sqa_pshift($past(q.preg), $past(q.sw1[1:0]));
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("accumulate add wrong");

  property p_acc_sub;
    go && wop == sqa_pkg::OP_SQ_SUB |=>
      q.acc == $past(q.acc) - sqa_pkg::sqa_pshift($past(q.preg), $past(q.sw1[1:0]));
  endproperty
  a_acc_sub: assert property (p_acc_sub) else $error("accumulate subtract wrong");

  property p_sq_acc_square;
    ce && q.st == sqa_pkg::SQA_CAPT && cur_op == sqa_pkg::OP_SQ_ACC |=>
      q.treg == $past(mem_rdata) &&
      q.preg == 32'($signed($past(mem_rdata)) * $signed($past(mem_rdata)));
  endproperty
  a_sq_acc_square: assert property (p_sq_acc_square) else $error("square accumulate load wrong");

  property p_sq_sub_load;
    go && wop == sqa_pkg::OP_SQ_SUB && ce |=> mem_rd ##1 (!mem_rd && q.st == sqa_pkg::SQA_CAPT);
  endproperty
  a_sq_sub_load: assert property (p_sq_sub_load) else $error("square subtract read sequence wrong");

  property p_signed_square;
    ce && q.st == sqa_pkg::SQA_CAPT && mem_rdata[15] |=> !q.preg[31];
  endproperty
  a_signed_square: assert property (p_signed_square) else $error("square of negative went negative");

  property p_shift_right;
    go && wop == sqa_pkg::OP_SQ_ACC && q.sw1[1:0] == 2'h3 |=>
      q.acc == $past(q.acc) + {{6{$past(q.preg[31])}}, $past(q.preg[31:6])};
  endproperty
  a_shift_right: assert property (p_shift_right) else $error("right shift six wrong");

  property p_store_sw0;
    go && wop == sqa_pkg::OP_STORE_S0 |=> mem_wr && mem_wdata == $past(q.sw0) && mem_addr == $past(agu_addr);
  endproperty
  a_store_sw0: assert property (p_store_sw0) else $error("status zero store wrong");

  property p_store_idx;
    go && wop == sqa_pkg::OP_STORE_IDX |=>
      mem_wr && mem_wdata == ($past(wval[sqa_pkg::CMD_IDX]) ? $past(q.sw1) : $past(q.sw0));
  endproperty
  a_store_idx: assert property (p_store_idx) else $error("indexed status store wrong");

  property p_store_sw1;
    go && wop == sqa_pkg::OP_STORE_S1 |=> mem_wr && mem_wdata == $past(q.sw1);
  endproperty
  a_store_sw1: assert property (p_store_sw1) else $error("status one store wrong");

  property p_set_sext;
    go && wop == sqa_pkg::OP_SET_SEXT |=> q.sw1 == ($past(q.sw1) | 16'h0400) && !mem_wr;
  endproperty
  a_set_sext: assert property (p_set_sext) else $error("sign extension set wrong");

  property p_set_test;
    go && wop == sqa_pkg::OP_SET_TEST |=> q.sw1 == ($past(q.sw1) | 16'h0800);
  endproperty
  a_set_test: assert property (p_set_test) else $error("test flag set wrong");

  property p_set_xmit;
    go && wop == sqa_pkg::OP_SET_XMIT |=>
      q.sw1 == ($past(q.legacy) ? ($past(q.sw1) | 16'h0004) : $past(q.sw1));
  endproperty
  a_set_xmit: assert property (p_set_xmit) else $error("transmit mode set wrong");

  property p_next_ptr;
    go && wop == sqa_pkg::OP_STORE_S0 && wval[sqa_pkg::CMD_IND] && wval[sqa_pkg::CMD_NXT_EN] |=>
      q.sw0[15:13] == $past(wval[15:13]) && mem_addr == $past(q.ar[q.sw0[15:13]]);
  endproperty
  a_next_ptr: assert property (p_next_ptr) else $error("next pointer load wrong");

  c_sq_acc_done: cover property (go && wop == sqa_pkg::OP_SQ_ACC ##[1:8] q.st == sqa_pkg::SQA_CAPT);
  c_store: cover property (go && wop == sqa_pkg::OP_STORE_IDX ##1 mem_wr);
  c_set_test: cover property (go && wop == sqa_pkg::OP_SET_TEST);
endmodule // sqa_top
`default_nettype wire

// File: testbench/sqa_mem_model.sv
// Behavioural data memory with a one-cycle read latency.
`timescale 1ns/1ns
`default_nettype none
module sqa_mem_model (
  input wire logic aclk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [15:0] mem_wdata,
  output logic [15:0] mem_rdata
);
  logic [15:0] mem [0:255];
  initial begin
    mem_rdata = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = {i[7:0], ~i[7:0]};
    end
  end
  // Outside a read cycle the data toggles, so stale data never passes for an answer.
  always @(posedge aclk) begin
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_wr) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule // sqa_mem_model
`default_nettype wire

// File: testbench/sqa_top_test.sv
// Self-checking bench for the square/accumulate and status-op unit.
`timescale 1ns/1ns
`default_nettype none
module sqa_top_test;
  localparam logic [1:0] OK = sqa_pkg::RESP_OKAY;
  localparam logic [1:0] ER = sqa_pkg::RESP_SLVERR;
  localparam logic [7:0] CMD = sqa_pkg::A_CMD;
  logic aclk, aresetn, ce;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] mem_addr, mem_wdata, mem_rdata, v;
  logic mem_rd, mem_wr;
  int bad_count, checked, cycles;
  integer seed;
  logic [31:0] rd_q[$], wr_q[$];
  logic [31:0] p, a, e, sq;
  logic [6:0] off;
  logic [3:0] op;
  logic pg;

  sqa_top i_sqa_top (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_addr,
    .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  sqa_mem_model i_sqa_mem_model (.aclk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    // The ready stays up after the answer so that back-to-back calls drive it once per step.
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask

  task automatic axr(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
    rd_q.push_back(ed);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask

  function automatic logic [31:0] shp(input logic [31:0] x, input logic [1:0] m);
    case (m)
      2'h1: return x << 1;
      2'h2: return x << 4;
      2'h3: return $signed(x) >>> 6;
      default: return x;
    endcase
  endfunction

  // Read data and memory writes are matched against the oldest expectation.
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      chk(s_axi_rdata, rd_q.pop_front());
    end
    if (mem_wr === 1'b1) begin
      chk({mem_addr, mem_wdata}, wr_q.pop_front());
    end
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    seed = 32'hED0412B6;
    aresetn = 1'b0;
    ce = 1'b1;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(8'h08, 32'h0000_0600, OK);
    axr(8'h0C, 32'h0000_05F0, OK);
    axr(8'h24, 32'h0, ER);
    axw(sqa_pkg::A_TREG, 32'h1, ER);
    axw(CMD, 32'hF, ER);
    for (int m = 0; m < 8; m++) begin
      p = $random(seed);
      a = $random(seed);
      off = 7'($random(seed));
      pg = m[0] ^ m[1];
      op = m[2] ? 4'h2 : 4'h1;
      v = {pg, off, ~pg, ~off};
      sq = $signed(v) * $signed(v);
      e = m[2] ? a - shp(p, m[1:0]) : a + shp(p, m[1:0]);
      // The page's low bit becomes address bit 7, so it picks the upper or lower half of the memory.
      axw(8'h08, {23'h3, 8'h00, pg}, OK);
      axw(8'h0C, {16'h0, 14'h017C, m[1:0]}, OK);
      axw(sqa_pkg::A_PREG, p, OK);
      // One pass freezes the unit while a write waits, which must only delay it.
      fork
        axw(sqa_pkg::A_ACC, a, OK);
        if (m == 5) begin
          ce <= 1'b0;
          repeat (3) @(posedge aclk);
          ce <= 1'b1;
        end
      join
      axw(CMD, {20'h0, off, 1'b0, op}, OK);
      repeat (3) @(posedge aclk);
      axr(sqa_pkg::A_ACC, e, OK);
      axr(sqa_pkg::A_PREG, sq, OK);
      axr(sqa_pkg::A_TREG, {16'h0, v}, OK);
    end
    axw(sqa_pkg::A_AUX, {13'h0, 3'h5, 16'h0042}, OK);
    axw(8'h08, 32'h0000_A661, OK);
    axw(8'h0C, 32'h0000_05F2, OK);
    wr_q.push_back(32'h3083_A661);
    axw(CMD, 32'h0000_0063, OK);
    wr_q.push_back(32'h3084_05F2);
    axw(CMD, 32'h0000_0085, OK);
    wr_q.push_back(32'h3085_05F2);
    axw(CMD, 32'h0001_00A4, OK);
    wr_q.push_back(32'h3086_A661);
    axw(CMD, 32'h0000_00C4, OK);
    wr_q.push_back(32'h0042_A661);
    axw(CMD, 32'h0000_5013, OK);
    repeat (2) @(posedge aclk);
    axr(8'h08, 32'h0000_4661, OK);
    axw(8'h0C, 32'h0000_01F0, OK);
    axw(CMD, 32'h6, OK);
    axr(8'h0C, 32'h0000_05F0, OK);
    axw(CMD, 32'h7, OK);
    axr(8'h0C, 32'h0000_0DF0, OK);
    axw(CMD, 32'h8, OK);
    axr(8'h0C, 32'h0000_0DF0, OK);
    axw(sqa_pkg::A_CFG, 32'h1, OK);
    axw(CMD, 32'h8, OK);
    axr(8'h0C, 32'h0000_0DF4, OK);
    repeat (4) @(posedge aclk);
    chk(wr_q.size(), 32'h0);
    close_out();
  end
endmodule // sqa_top_test
`default_nettype wire
